// ---- core/gso_pkg.sv ----
// Package for the status output select block: function codes and timing.
// Assumes a single 40 MHz core clock.
package gso_pkg;
  localparam int CODE_W = 6;
  typedef logic [CODE_W-1:0] gso_code_t;
  localparam gso_code_t FN_SEQ_DONE = 6'h15;
  localparam gso_code_t FN_ADDR_ERR = 6'h16;
  localparam gso_code_t FN_IN_OVF = 6'h17;
  localparam gso_code_t FN_IN_DEC_ERR = 6'h18;
  localparam gso_code_t FN_IN_FIFO_ERR = 6'h19;
  localparam gso_code_t FN_RC1_LOCK = 6'h1a;
  localparam gso_code_t FN_RC2_LOCK = 6'h1b;
  localparam gso_code_t FN_RC_CFG_ERR = 6'h1c;
  localparam gso_code_t FN_C1_DETECT = 6'h1d;
  localparam gso_code_t FN_C1_ACLIP = 6'h1e;
  localparam gso_code_t FN_C1_DECAY = 6'h1f;
  localparam gso_code_t FN_C1_GATE = 6'h20;
  localparam gso_code_t FN_C1_QREL = 6'h21;
  localparam gso_code_t FN_C2_DETECT = 6'h22;
  localparam gso_code_t FN_C2_ACLIP = 6'h23;
  localparam gso_code_t FN_C2_DECAY = 6'h24;
  localparam gso_code_t FN_C2_GATE = 6'h25;
  localparam gso_code_t FN_C2_QREL = 6'h26;
  localparam gso_code_t FN_MIX_DROP = 6'h27;
  localparam gso_code_t FN_RESET = 6'h00;
  // Sequencer-done pulse width on the pin
  localparam int CLK_MHZ = 40;
  localparam int PULSE_NS = 100;
  localparam int PULSE_CYC_RAW = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_CYC = (PULSE_CYC_RAW < 1) ? 1 : PULSE_CYC_RAW;
  localparam int PULSE_W = 4;
  typedef enum logic [0:0] {
    GSO_IDLE = 1'b0,
    GSO_PULSE = 1'b1
  } gso_state_e;
endpackage

// ---- core/gso_if.sv ----
// Interface between the pin selector and its pulse stretcher.
// Assumes both ends share core_clk.
`timescale 1ns/1ps
interface gso_pulse_if;
  logic trigger;
  logic pulse;
  modport source (output trigger, input pulse);
  modport stretcher (input trigger, output pulse);
endinterface

// ---- core/gso_stretch.sv ----
// Stretches a one-cycle trigger into a fixed-width pulse.
// Assumes trigger comes from logic on the same clock.
`timescale 1ns/1ps
module gso_stretch #(
  parameter int WIDTH = gso_pkg::PULSE_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  gso_pulse_if.stretcher port
);
  import gso_pkg::*;

  // Refuse widths the counter cannot count out; zero would wrap it
  if (WIDTH < 1 || WIDTH >= (1 << PULSE_W)) begin : g_bad_width
    $error("gso_stretch: WIDTH out of range");
  end

  localparam logic [PULSE_W-1:0] LAST = PULSE_W'(WIDTH - 1);

  gso_state_e state;
  gso_state_e next_state;
  logic [PULSE_W-1:0] count;
  logic [PULSE_W-1:0] next_count;

  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      GSO_IDLE: begin
        next_count = '0;
        if (port.trigger) begin
          next_state = GSO_PULSE;
        end
      end
      GSO_PULSE: begin
        if (count == LAST) begin
          next_state = GSO_IDLE;
          next_count = '0;
        end else begin
          next_count = count + 4'h1;
        end
      end
      default: begin
        next_state = GSO_IDLE;
        next_count = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= GSO_IDLE;
      count <= '0;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign port.pulse = (state == GSO_PULSE);
endmodule

// ---- core/gso_select.sv ----
// Pin output selector for status, error and event functions 15h..27h.
// Assumes all status inputs are levels from logic on core_clk, the
// sequencer-done input is a one-cycle pulse on core_clk, and the pin
// direction is set to output by software.
//
// Summary of operation
// - Each pin has its own function code
// - 15h: pulse when sequencer finishes
// - 16h: high on control address error
// - 17h: high on input path overflow
// - 18h: high on decimation filter error
// - 19h: high on input FIFO error
// - 1Ah: high while converter one locked
// - 1Bh: high while converter two locked
// - 1Ch: high on converter configuration error
// - 1Dh: compressor one signal detect
// - 1Eh: compressor one anti-clip active
// - 1Fh: compressor one decay active
// - 20h: compressor one noise gate active
// - 21h: compressor one quick release
// - 22h: compressor two signal detect
// - 23h: compressor two anti-clip active
// - 24h: compressor two decay active
// - 25h: compressor two noise gate
// - 26h: compressor two quick release
// - 27h: high on mixer dropped sample
`timescale 1ns/1ps
module gso_select #(
  parameter int PULSE_WIDTH = gso_pkg::PULSE_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire gso_pkg::gso_code_t pin_function_select,
  input wire logic pin_direction,
  input wire logic seq_done,
  input wire logic addr_err,
  input wire logic in_overflow,
  input wire logic in_decim_err,
  input wire logic in_fifo_err,
  input wire logic rate_converter_one_lock,
  input wire logic rate_converter_two_lock,
  input wire logic rate_converter_cfg_err,
  input wire logic range_compressor_one_detect,
  input wire logic range_compressor_one_anticlip,
  input wire logic range_compressor_one_decay,
  input wire logic range_compressor_one_gate,
  input wire logic range_compressor_one_qrel,
  input wire logic range_compressor_two_detect,
  input wire logic range_compressor_two_anticlip,
  input wire logic range_compressor_two_decay,
  input wire logic range_compressor_two_gate,
  input wire logic range_compressor_two_qrel,
  input wire logic mixer_drop,
  output logic pin_out,
  output logic pin_oe,
  output logic code_known
);
  import gso_pkg::*;

  // Served codes form one run from 15h up; bit 0 of each vector is 15h
  localparam int NUM_FN = int'(FN_MIX_DROP) - int'(FN_SEQ_DONE) + 1;
  localparam int IX_SEQ_DONE = int'(FN_SEQ_DONE) - int'(FN_SEQ_DONE);
  localparam int IX_ADDR_ERR = int'(FN_ADDR_ERR) - int'(FN_SEQ_DONE);
  localparam int IX_IN_OVF = int'(FN_IN_OVF) - int'(FN_SEQ_DONE);
  localparam int IX_IN_DEC_ERR = int'(FN_IN_DEC_ERR) - int'(FN_SEQ_DONE);
  localparam int IX_IN_FIFO_ERR = int'(FN_IN_FIFO_ERR) - int'(FN_SEQ_DONE);
  localparam int IX_RC1_LOCK = int'(FN_RC1_LOCK) - int'(FN_SEQ_DONE);
  localparam int IX_RC2_LOCK = int'(FN_RC2_LOCK) - int'(FN_SEQ_DONE);
  localparam int IX_RC_CFG_ERR = int'(FN_RC_CFG_ERR) - int'(FN_SEQ_DONE);
  localparam int IX_C1_DETECT = int'(FN_C1_DETECT) - int'(FN_SEQ_DONE);
  localparam int IX_C1_ACLIP = int'(FN_C1_ACLIP) - int'(FN_SEQ_DONE);
  localparam int IX_C1_DECAY = int'(FN_C1_DECAY) - int'(FN_SEQ_DONE);
  localparam int IX_C1_GATE = int'(FN_C1_GATE) - int'(FN_SEQ_DONE);
  localparam int IX_C1_QREL = int'(FN_C1_QREL) - int'(FN_SEQ_DONE);
  localparam int IX_C2_DETECT = int'(FN_C2_DETECT) - int'(FN_SEQ_DONE);
  localparam int IX_C2_ACLIP = int'(FN_C2_ACLIP) - int'(FN_SEQ_DONE);
  localparam int IX_C2_DECAY = int'(FN_C2_DECAY) - int'(FN_SEQ_DONE);
  localparam int IX_C2_GATE = int'(FN_C2_GATE) - int'(FN_SEQ_DONE);
  localparam int IX_C2_QREL = int'(FN_C2_QREL) - int'(FN_SEQ_DONE);
  localparam int IX_MIX_DROP = int'(FN_MIX_DROP) - int'(FN_SEQ_DONE);

  // The stretcher counter has PULSE_W bits, so longer pulses cannot be
  // counted out; zero would wrap the counter
  if (PULSE_WIDTH < 1 || PULSE_WIDTH >= (1 << PULSE_W)) begin : g_bad_width
    $error("gso_select: PULSE_WIDTH out of range");
  end

  gso_pulse_if pulse_bus ();

  assign pulse_bus.trigger = seq_done;

  gso_stretch #(
    .WIDTH(PULSE_WIDTH)
  ) u_stretch (
    .core_clk(core_clk),
    .rst(rst),
    .port(pulse_bus.stretcher)
  );

  // One bit per served code; all are levels except the done pulse
  logic [NUM_FN-1:0] src;
  logic [NUM_FN-1:0] hit;

  always_comb begin
    src[IX_SEQ_DONE] = pulse_bus.pulse;
    src[IX_ADDR_ERR] = addr_err;
    src[IX_IN_OVF] = in_overflow;
    src[IX_IN_DEC_ERR] = in_decim_err;
    src[IX_IN_FIFO_ERR] = in_fifo_err;
    src[IX_RC1_LOCK] = rate_converter_one_lock;
    src[IX_RC2_LOCK] = rate_converter_two_lock;
    src[IX_RC_CFG_ERR] = rate_converter_cfg_err;
    src[IX_C1_DETECT] = range_compressor_one_detect;
    src[IX_C1_ACLIP] = range_compressor_one_anticlip;
    src[IX_C1_DECAY] = range_compressor_one_decay;
    src[IX_C1_GATE] = range_compressor_one_gate;
    src[IX_C1_QREL] = range_compressor_one_qrel;
    src[IX_C2_DETECT] = range_compressor_two_detect;
    src[IX_C2_ACLIP] = range_compressor_two_anticlip;
    src[IX_C2_DECAY] = range_compressor_two_decay;
    src[IX_C2_GATE] = range_compressor_two_gate;
    src[IX_C2_QREL] = range_compressor_two_qrel;
    src[IX_MIX_DROP] = mixer_drop;
  end

  always_comb begin
    hit = '0;
    case (pin_function_select)
      FN_SEQ_DONE: begin
        hit[IX_SEQ_DONE] = 1'b1;
      end
      FN_ADDR_ERR: begin
        hit[IX_ADDR_ERR] = 1'b1;
      end
      FN_IN_OVF: begin
        hit[IX_IN_OVF] = 1'b1;
      end
      FN_IN_DEC_ERR: begin
        hit[IX_IN_DEC_ERR] = 1'b1;
      end
      FN_IN_FIFO_ERR: begin
        hit[IX_IN_FIFO_ERR] = 1'b1;
      end
      FN_RC1_LOCK: begin
        hit[IX_RC1_LOCK] = 1'b1;
      end
      FN_RC2_LOCK: begin
        hit[IX_RC2_LOCK] = 1'b1;
      end
      FN_RC_CFG_ERR: begin
        hit[IX_RC_CFG_ERR] = 1'b1;
      end
      FN_C1_DETECT: begin
        hit[IX_C1_DETECT] = 1'b1;
      end
      FN_C1_ACLIP: begin
        hit[IX_C1_ACLIP] = 1'b1;
      end
      FN_C1_DECAY: begin
        hit[IX_C1_DECAY] = 1'b1;
      end
      FN_C1_GATE: begin
        hit[IX_C1_GATE] = 1'b1;
      end
      FN_C1_QREL: begin
        hit[IX_C1_QREL] = 1'b1;
      end
      FN_C2_DETECT: begin
        hit[IX_C2_DETECT] = 1'b1;
      end
      FN_C2_ACLIP: begin
        hit[IX_C2_ACLIP] = 1'b1;
      end
      FN_C2_DECAY: begin
        hit[IX_C2_DECAY] = 1'b1;
      end
      FN_C2_GATE: begin
        hit[IX_C2_GATE] = 1'b1;
      end
      FN_C2_QREL: begin
        hit[IX_C2_QREL] = 1'b1;
      end
      FN_MIX_DROP: begin
        hit[IX_MIX_DROP] = 1'b1;
      end
      // Codes outside this block's range are served elsewhere
      default: begin
        hit = '0;
      end
    endcase
  end

  logic next_pin_out;
  logic next_pin_oe;
  logic next_code_known;

  // One-hot AND-OR select: no priority chain behind the pin register
  always_comb begin
    next_code_known = |hit;
    // Drive only when set as output, and only for served codes
    next_pin_oe = next_code_known & ~pin_direction;
    next_pin_out = next_pin_oe & (|(hit & src));
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
      code_known <= 1'b0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      code_known <= next_code_known;
    end
  end
endmodule

// ---- testbench/gso_chk.sv ----
// Port checks for the status pin selector.
// Assumes one clock domain and an active-high reset.
`timescale 1ns/1ps
module gso_chk import gso_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  input wire gso_pkg::gso_code_t pin_function_select,
  input wire logic pin_direction,
  input wire logic addr_err,
  input wire logic rate_converter_cfg_err,
  input wire logic mixer_drop,
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic code_known
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic sel, drv;
  gso_code_t c;
  assign c = pin_function_select;
  assign sel = c == FN_SEQ_DONE && !pin_direction;
  assign drv = c inside {[FN_SEQ_DONE:FN_MIX_DROP]};
  // A fresh pulse: code was already 15h before the rise
  sequence s_start;
    $rose(pin_out) && $past(sel) && $past(sel, 2);
  endsequence
  sequence s_held;
    s_start ##0 sel[*4];
  endsequence
  a_done_width: assert property (s_held |-> pin_out && $past(pin_out)
    && $past(pin_out, 2) ##1 !pin_out) else $error("done pulse width");
  a_code_known: assert property (1'b1 |=> code_known == $past(drv))
    else $error("code_known wrong");
  a_refused_off: assert property (!drv |=> !pin_oe && !pin_out)
    else $error("unknown code drives pin");
  a_dir_input: assert property (pin_direction |=> !pin_oe && !pin_out)
    else $error("input pin driven");
  a_oe_on: assert property (drv && !pin_direction |=> pin_oe)
    else $error("pin not driven");
  a_addr_level: assert property (c == FN_ADDR_ERR && !pin_direction
    |=> pin_out == $past(addr_err)) else $error("addr level");
  a_cfg_level: assert property (c == FN_RC_CFG_ERR && !pin_direction
    |=> pin_out == $past(rate_converter_cfg_err)) else $error("cfg level");
  a_drop_level: assert property (c == FN_MIX_DROP && !pin_direction
    |=> pin_out == $past(mixer_drop)) else $error("drop level");
endmodule
bind gso_select gso_chk chk (.*);

// ---- testbench/gso_mon.sv ----
// Far-side host: sets pin direction and reads the pin.
// Assumes the pin has no pull resistor.
`timescale 1ns/1ps
module gso_mon (
  input wire logic core_clk,
  input wire logic want_input,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pin_direction,
  output logic pin_lvl
);
  logic last = 1'b0;
  assign pin_direction = want_input;
  // Released pin floats, so show the inverse of the last driven level
  assign pin_lvl = pin_oe ? pin_out : ~last;
  always @(posedge core_clk) begin
    if (pin_oe) begin
      last <= pin_out;
    end
  end
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the status pin selector.
// Assumes the default four-cycle done pulse.
`timescale 1ns/1ps
module tb_top;
  import gso_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, seq = 1'b0, w = 1'b0;
  logic d, lvl, po, oe, kn;
  logic [17:0] v = '0;
  gso_code_t code = FN_RESET;
  gso_code_t bad[4] = '{6'h14, 6'h28, 6'h00, 6'h3f};
  int fail_count = 0, n_compared = 0, n;
  always #12.5 core_clk = ~core_clk;
  gso_mon mon (.core_clk(core_clk), .want_input(w), .pin_out(po),
    .pin_oe(oe), .pin_direction(d), .pin_lvl(lvl));
  gso_select uut (.core_clk(core_clk), .rst(rst),
    .pin_function_select(code), .pin_direction(d), .seq_done(seq),
    .addr_err(v[0]), .in_overflow(v[1]), .in_decim_err(v[2]),
    .in_fifo_err(v[3]), .rate_converter_one_lock(v[4]),
    .rate_converter_two_lock(v[5]), .rate_converter_cfg_err(v[6]),
    .range_compressor_one_detect(v[7]),
    .range_compressor_one_anticlip(v[8]),
    .range_compressor_one_decay(v[9]), .range_compressor_one_gate(v[10]),
    .range_compressor_one_qrel(v[11]),
    .range_compressor_two_detect(v[12]),
    .range_compressor_two_anticlip(v[13]),
    .range_compressor_two_decay(v[14]), .range_compressor_two_gate(v[15]),
    .range_compressor_two_qrel(v[16]), .mixer_drop(v[17]),
    .pin_out(po), .pin_oe(oe), .code_known(kn));
  task automatic check(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic apply(input gso_code_t c, input logic dr,
    input logic [17:0] x);
    @(posedge core_clk);
    code <= c;
    w <= dr;
    v <= x;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 18; i++) begin
      apply(FN_ADDR_ERR + 6'(i), 1'b0, 18'h1 << i);
      check(lvl, 1'b1);
      check(kn, 1'b1);
      apply(FN_ADDR_ERR + 6'(i), 1'b0, ~(18'h1 << i));
      check(lvl, 1'b0);
    end
    $display("level codes done");
    for (int i = 0; i < 4; i++) begin
      apply(bad[i], 1'b0, '1);
      check(oe, 1'b0);
      check(po | kn, 1'b0);
    end
    apply(FN_ADDR_ERR, 1'b1, '1);
    check(oe | po, 1'b0);
    $display("refusals done");
    apply(FN_SEQ_DONE, 1'b0, '1);
    check(lvl, 1'b0);
    for (int r = 0; r < 2; r++) begin
      n = 0;
      for (int i = 0; i < 12; i++) begin
        @(posedge core_clk);
        seq <= (i <= r);
        #1 n += int'(po);
      end
      check(n == PULSE_CYC, 1'b1);
    end
    $display("done pulse done");
    end_sim();
  end
endmodule
